/* File: src/piv_map.svh */
// Constant map of the interrupt expansion unit: codes, flags and priorities.
`ifndef PIV_MAP_SVH
`define PIV_MAP_SVH

// Number of peripheral sources handled and core lines driven.
`define PIV_NSRC        16
`define PIV_NLINE       6
`define PIV_NFLAG       48

// Fixed entry vectors of the unarbitrated entries.
`define PIV_VEC_RESET   16'h0000
`define PIV_VEC_EMU     16'h0026
`define PIV_VEC_NMI     16'h0024
// Code returned when an acknowledge finds nothing pending.
`define PIV_VEC_PHANTOM 16'h0000

// Per-source tables, source 0 in the lowest slice. Source order:
// converter, pin a, pin b, sync serial, async rx, async tx, can mailbox,
// can error, timer a period/compare/underflow/overflow, timer c same.
// Flag position is register * 16 + bit.
`define PIV_POS_HI  {6'h27, 6'h26, 6'h25, 6'h24, 6'h0f, 6'h0e, 6'h0d, \
  6'h0c, 6'h08, 6'h07, 6'h06, 6'h05, 6'h04, 6'h03, 6'h02, 6'h01}
`define PIV_POS_LO  {6'h27, 6'h26, 6'h25, 6'h24, 6'h0f, 6'h0e, 6'h0d, \
  6'h0c, 6'h1b, 6'h1a, 6'h19, 6'h18, 6'h17, 6'h1e, 6'h1d, 6'h1c}
`define PIV_PRI_HI  {6'h1b, 6'h1a, 6'h19, 6'h18, 6'h14, 6'h13, 6'h12, \
  6'h11, 6'h0d, 6'h0c, 6'h0b, 6'h0a, 6'h09, 6'h08, 6'h07, 6'h06}
`define PIV_PRI_LO  {6'h1b, 6'h1a, 6'h19, 6'h18, 6'h14, 6'h13, 6'h12, \
  6'h11, 6'h2e, 6'h2d, 6'h2c, 6'h2b, 6'h2a, 6'h31, 6'h30, 6'h2f}
`define PIV_LINE_HI {3'h2, 3'h2, 3'h2, 3'h2, 3'h2, 3'h2, 3'h2, 3'h2, \
  3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1}
`define PIV_LINE_LO {3'h2, 3'h2, 3'h2, 3'h2, 3'h2, 3'h2, 3'h2, 3'h2, \
  3'h5, 3'h5, 3'h5, 3'h5, 3'h5, 3'h6, 3'h6, 3'h5}
`define PIV_CODE    {16'h0032, 16'h0031, 16'h0030, 16'h002f, \
  16'h002a, 16'h0029, 16'h0028, 16'h0027, 16'h0041, 16'h0040, \
  16'h0007, 16'h0006, 16'h0005, 16'h0011, 16'h0001, 16'h0004}

`endif

/* File: src/piv_pkg.sv */
// Types shared by the interrupt expansion unit.
package piv_pkg;

  // Registered state of the expansion unit, all but the reset synchroniser.
  typedef struct packed {
    logic [47:0] pend;     // Pending request flags, three 16-bit registers.
    logic [47:0] ack;      // Acknowledge flags, one pulse per acknowledge that finds a source.
    logic [15:0] code;     // Last source vector code handed to the core.
    logic        code_vld; // Code valid pulse.
    logic [5:0]  irq;      // Core line requests, line one in bit 0.
    logic        ent_req;  // Unarbitrated entry request pulse.
    logic [15:0] ent_vec;  // Vector of that entry.
  } piv_state_s;

endpackage

/* File: src/piv_top.sv */
// Interrupt expansion unit: groups peripheral sources onto core lines.
`timescale 1ns/10ps
`include "piv_map.svh"

// How it works
// - reset entry: priority one, vector zero, unmaskable.
// - nonmaskable entry at 0024h, software only.
// - converter on line one, flag 0.1, code 0004h.
// - pins a/b on line one, flags 0.2/0.3.
// - sync serial on line one, flag 0.4.
// - async receiver on line one, flag 0.5.
// - async transmitter on line one, flag 0.6.
// - can mailbox on line one, flag 0.7.
// - can error on line one, flag 0.8.
// - timer a period: line two, flag 0.12.
// - timer a compare: line two, flag 0.13.
// - timer a underflow: line two, flag 0.14.
// - timer a overflow: line two, flag 0.15.
// - timer c period: line two, flag 2.4.
// - timer c compare: line two, flag 2.5.
// - timer c underflow: line two, flag 2.6.
// - timer c overflow: line two, flag 2.7.
// - absent peripherals never raise a request.
// - low mode moves the non-timer sources to register one, lines five/six.
// - sources grouped on lines one, two, five and six, unique codes.
// - source enable and core mask both gate.
module piv_top
  import piv_pkg::*;
#(
  // One bit per source; a zero marks a peripheral absent on this variant.
  parameter logic [15:0] PRESENT = 16'hffff
)(
  // Clock, reset and clock enable.
  input  wire logic        SYS_CLK,
  input  wire logic        NRST,
  input  wire logic        CE,
  // Source events and configuration.
  input  wire logic [15:0] SRC_IRQ,
  input  wire logic [15:0] SRC_EN,
  input  wire logic        LOW_PRI_MODE,
  input  wire logic [5:0]  CORE_MASK,
  // Unarbitrated entries.
  input  wire logic        WDOG_TIMEOUT,
  input  wire logic        EMU_TRAP,
  input  wire logic        SW_NMI,
  // Acknowledge from the core.
  input  wire logic        ACK_VALID,
  input  wire logic [2:0]  ACK_LINE,
  // Requests and status towards the core.
  output logic      [5:0]  CORE_IRQ,
  output logic      [15:0] VEC_CODE,
  output logic             VEC_VALID,
  output logic      [47:0] PENDING_FLAGS,
  output logic      [47:0] ACK_FLAGS,
  output logic             ENTRY_REQ,
  output logic      [15:0] ENTRY_VEC
);

  // Flattened lookup tables, one slice per source.
  localparam logic [95:0]  POS_HI  = `PIV_POS_HI;
  localparam logic [95:0]  POS_LO  = `PIV_POS_LO;
  localparam logic [95:0]  PRI_HI  = `PIV_PRI_HI;
  localparam logic [95:0]  PRI_LO  = `PIV_PRI_LO;
  localparam logic [47:0]  LINE_HI = `PIV_LINE_HI;
  localparam logic [47:0]  LINE_LO = `PIV_LINE_LO;
  localparam logic [255:0] CODES   = `PIV_CODE;

  logic       rst_meta_q;  // First reset synchroniser stage.
  logic       rst_n;       // Released reset used by all other logic.
  piv_state_s s_q;         // Registered state.
  piv_state_s s_d;         // Next state.
  logic [5:0] pos   [16];  // Flag position of each source in this mode.
  logic [5:0] pri   [16];  // Overall priority of each source.
  logic [2:0] line  [16];  // Core line number of each source.
  logic [15:0] act;        // Source flag pending and peripheral present.

  // Reset is released through two flops so that all state leaves reset
  // on the same edge; assertion stays asynchronous.
  always_ff @(posedge SYS_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  // Table lookup follows the priority mode; timers ignore the mode.
  always_comb
  begin
    for (int i = 0; i < 16; i++)
    begin
      if (LOW_PRI_MODE)
      begin
        pos[i]  = POS_LO[i*6 +: 6];
        pri[i]  = PRI_LO[i*6 +: 6];
        line[i] = LINE_LO[i*3 +: 3];
      end
      else
      begin
        pos[i]  = POS_HI[i*6 +: 6];
        pri[i]  = PRI_HI[i*6 +: 6];
        line[i] = LINE_HI[i*3 +: 3];
      end
      act[i] = s_q.pend[pos[i]] & PRESENT[i];
    end
  end

  // Next state: acknowledge arbitration, flag set and clear, line levels
  // and the unarbitrated entries.
  always_comb
  begin
    logic       found;
    logic [3:0] bi;
    logic [5:0] bp;
    found = 1'b0;
    bi    = 4'h0;
    bp    = 6'h3f;
    s_d          = s_q;
    s_d.ack      = '0;
    s_d.code_vld = 1'b0;
    s_d.ent_req  = 1'b0;
    // Pick the pending source of the acknowledged line with the lowest
    // priority number; table order is not trusted for this.
    for (int i = 0; i < 16; i++)
    begin
      if (act[i] && line[i] == ACK_LINE && (!found || pri[i] < bp))
      begin
        found = 1'b1;
        bi    = 4'(i);
        bp    = pri[i];
      end
    end
    if (ACK_VALID)
    begin
      s_d.code_vld = 1'b1;
      if (found)
      begin
        s_d.code          = CODES[bi*16 +: 16];
        s_d.pend[pos[bi]] = 1'b0;
        s_d.ack[pos[bi]]  = 1'b1;
      end
      else
      begin
        // Nothing left to serve: hand back the phantom code.
        s_d.code = `PIV_VEC_PHANTOM;
      end
    end
    // Setting follows the clear so a new event in the acknowledge cycle
    // is kept. Disabled events are dropped at the source.
    for (int i = 0; i < 16; i++)
    begin
      if (SRC_IRQ[i] && SRC_EN[i] && PRESENT[i])
      begin
        s_d.pend[pos[i]] = 1'b1;
      end
    end
    // A line stays up while its core mask bit is set and any present source of it remains pending.
    for (int l = 0; l < 6; l++)
    begin
      s_d.irq[l] = 1'b0;
      for (int i = 0; i < 16; i++)
      begin
        if (s_d.pend[pos[i]] && PRESENT[i] && line[i] == 3'(l + 1))
        begin
          s_d.irq[l] = CORE_MASK[l];
        end
      end
    end
    // Watchdog reset beats the emulator trap, which beats the software
    // nonmaskable entry; no hardware input reaches the latter.
    if (WDOG_TIMEOUT)
    begin
      s_d.ent_req = 1'b1;
      s_d.ent_vec = `PIV_VEC_RESET;
    end
    else if (EMU_TRAP)
    begin
      s_d.ent_req = 1'b1;
      s_d.ent_vec = `PIV_VEC_EMU;
    end
    else if (SW_NMI)
    begin
      s_d.ent_req = 1'b1;
      s_d.ent_vec = `PIV_VEC_NMI;
    end
  end

  // State register. After reset the reset entry is presented once.
  always_ff @(posedge SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q         <= '0;
      s_q.ent_req <= 1'b1;
      s_q.ent_vec <= `PIV_VEC_RESET;
    end
    else if (CE)
    begin
      s_q <= s_d;
    end
  end

  // Outputs come straight from the state flops.
  assign CORE_IRQ      = s_q.irq;
  assign VEC_CODE      = s_q.code;
  assign VEC_VALID     = s_q.code_vld;
  assign PENDING_FLAGS = s_q.pend;
  assign ACK_FLAGS     = s_q.ack;
  assign ENTRY_REQ     = s_q.ent_req;
  assign ENTRY_VEC     = s_q.ent_vec;

  // Checks on the registered behaviour. The |=> ones look one edge after
  // the event, because every output is a flop; the |-> ones check the same edge.
  reset_vec_a: assert property (
    @(posedge SYS_CLK) disable iff (!rst_n)
    CE && WDOG_TIMEOUT |=> ENTRY_REQ && ENTRY_VEC == 16'h0000)
    else $error("Watchdog reset did not present vector zero.");

  nmi_vec_a: assert property (
    @(posedge SYS_CLK) disable iff (!rst_n)
    CE && SW_NMI && !WDOG_TIMEOUT && !EMU_TRAP
    |=> ENTRY_REQ && ENTRY_VEC == 16'h0024)
    else $error("Software nonmaskable entry has wrong vector.");

  // A frozen clock enable keeps the pulse up, so that cycle is excused.
  nmi_source_a: assert property (
    @(posedge SYS_CLK) disable iff (!rst_n)
    ENTRY_REQ && ENTRY_VEC == 16'h0024 |-> $past(SW_NMI) || !$past(CE))
    else $error("Nonmaskable entry raised without software.");

  conv_flag_a: assert property (
    @(posedge SYS_CLK) disable iff (!rst_n)
    CE && !LOW_PRI_MODE && SRC_IRQ[0] && SRC_EN[0] && PRESENT[0]
    |=> PENDING_FLAGS[1])
    else $error("Converter event did not set flag 0.1.");

  pin_a_flag_a: assert property (
    @(posedge SYS_CLK) disable iff (!rst_n)
    CE && !LOW_PRI_MODE && SRC_IRQ[1] && SRC_EN[1] && PRESENT[1]
    |=> PENDING_FLAGS[2])
    else $error("Pin a event did not set flag 0.2.");

  pin_b_flag_a: assert property (
    @(posedge SYS_CLK) disable iff (!rst_n)
    CE && !LOW_PRI_MODE && SRC_IRQ[2] && SRC_EN[2] && PRESENT[2]
    |=> PENDING_FLAGS[3])
    else $error("Pin b event did not set flag 0.3.");

  sync_flag_a: assert property (
    @(posedge SYS_CLK) disable iff (!rst_n)
    CE && !LOW_PRI_MODE && SRC_IRQ[3] && SRC_EN[3] && PRESENT[3]
    |=> PENDING_FLAGS[4])
    else $error("Sync serial event did not set flag 0.4.");

  rx_flag_a: assert property (
    @(posedge SYS_CLK) disable iff (!rst_n)
    CE && !LOW_PRI_MODE && SRC_IRQ[4] && SRC_EN[4] && PRESENT[4]
    |=> PENDING_FLAGS[5])
    else $error("Async receive event did not set flag 0.5.");

  tx_flag_a: assert property (
    @(posedge SYS_CLK) disable iff (!rst_n)
    CE && !LOW_PRI_MODE && SRC_IRQ[5] && SRC_EN[5] && PRESENT[5]
    |=> PENDING_FLAGS[6])
    else $error("Async transmit event did not set flag 0.6.");

  mbox_flag_a: assert property (
    @(posedge SYS_CLK) disable iff (!rst_n)
    CE && !LOW_PRI_MODE && SRC_IRQ[6] && SRC_EN[6] && PRESENT[6]
    |=> PENDING_FLAGS[7])
    else $error("Mailbox event did not set flag 0.7.");

  err_flag_a: assert property (
    @(posedge SYS_CLK) disable iff (!rst_n)
    CE && !LOW_PRI_MODE && SRC_IRQ[7] && SRC_EN[7] && PRESENT[7]
    |=> PENDING_FLAGS[8])
    else $error("Bus error event did not set flag 0.8.");

  tmr_a_per_a: assert property (
    @(posedge SYS_CLK) disable iff (!rst_n)
    CE && SRC_IRQ[8] && SRC_EN[8] && PRESENT[8]
    |=> PENDING_FLAGS[12])
    else $error("Timer a period event did not set flag 0.12.");

  tmr_a_cmp_a: assert property (
    @(posedge SYS_CLK) disable iff (!rst_n)
    CE && SRC_IRQ[9] && SRC_EN[9] && PRESENT[9]
    |=> PENDING_FLAGS[13])
    else $error("Timer a compare event did not set flag 0.13.");

  tmr_a_under_a: assert property (
    @(posedge SYS_CLK) disable iff (!rst_n)
    CE && SRC_IRQ[10] && SRC_EN[10] && PRESENT[10]
    |=> PENDING_FLAGS[14])
    else $error("Timer a underflow event did not set flag 0.14.");

  tmr_a_over_a: assert property (
    @(posedge SYS_CLK) disable iff (!rst_n)
    CE && SRC_IRQ[11] && SRC_EN[11] && PRESENT[11]
    |=> PENDING_FLAGS[15])
    else $error("Timer a overflow event did not set flag 0.15.");

  tmr_c_flag_a: assert property (
    @(posedge SYS_CLK) disable iff (!rst_n)
    CE && SRC_IRQ[12] && SRC_EN[12] && PRESENT[12]
    |=> PENDING_FLAGS[36])
    else $error("Timer c period event did not set flag 2.4.");

  tmr_c_cmp_a: assert property (
    @(posedge SYS_CLK) disable iff (!rst_n)
    CE && SRC_IRQ[13] && SRC_EN[13] && PRESENT[13]
    |=> PENDING_FLAGS[37])
    else $error("Timer c compare event did not set flag 2.5.");

  tmr_c_under_a: assert property (
    @(posedge SYS_CLK) disable iff (!rst_n)
    CE && SRC_IRQ[14] && SRC_EN[14] && PRESENT[14]
    |=> PENDING_FLAGS[38])
    else $error("Timer c underflow event did not set flag 2.6.");

  tmr_c_over_a: assert property (
    @(posedge SYS_CLK) disable iff (!rst_n)
    CE && SRC_IRQ[15] && SRC_EN[15] && PRESENT[15]
    |=> PENDING_FLAGS[39])
    else $error("Timer c overflow event did not set flag 2.7.");

  low_mode_a: assert property (
    @(posedge SYS_CLK) disable iff (!rst_n)
    CE && LOW_PRI_MODE && SRC_IRQ[3] && SRC_EN[3] && PRESENT[3]
    |=> PENDING_FLAGS[23] && !$changed(PENDING_FLAGS[4]))
    else $error("Low mode serial event used the wrong flag.");

  low_line_a: assert property (
    @(posedge SYS_CLK) disable iff (!rst_n)
    CE && LOW_PRI_MODE && CORE_MASK[4] && SRC_IRQ[4] && SRC_EN[4]
    && PRESENT[4] |=> CORE_IRQ[4])
    else $error("Low mode receive event did not raise line five.");

  // Reset clears the flag and nothing may set it afterwards.
  absent_src_a: assert property (
    @(posedge SYS_CLK) disable iff (!rst_n)
    !PRESENT[8] |-> !PENDING_FLAGS[12])
    else $error("Absent timer source raised a flag.");

  mask_gate_a: assert property (
    @(posedge SYS_CLK) disable iff (!rst_n)
    CE && !CORE_MASK[1] |=> !CORE_IRQ[1])
    else $error("Masked core line two was raised.");

  ack_pick_a: assert property (
    @(posedge SYS_CLK) disable iff (!rst_n)
    CE && ACK_VALID && ACK_LINE == 3'h2 && act[8] && act[9]
    |=> VEC_VALID && VEC_CODE == 16'h0027 && ACK_FLAGS[12])
    else $error("Acknowledge did not take the highest priority source.");

  // The line level was built from the mask of the previous edge.
  line_hold_a: assert property (
    @(posedge SYS_CLK) disable iff (!rst_n)
    CE && $past(CE) && $past(CORE_MASK[1])
    && PENDING_FLAGS[15] && PRESENT[11] |-> CORE_IRQ[1])
    else $error("Line two dropped while a timer flag was pending.");

endmodule

/* File: tb/piv_core_model.sv */
// Behavioural core that acknowledges the interrupt lines raised to it.
`timescale 1ns/10ps
module piv_core_model (
  // Clock.
  input  wire logic       clk,
  // Line requests and test controls.
  input  wire logic [5:0] irq,
  input  wire logic       go,
  input  wire logic [3:0] lag,
  // Acknowledge towards the expansion unit.
  output logic            ack_valid,
  output logic [2:0]      ack_line
);
  logic [3:0] wait_q = 4'h0; // Cycles waited before answering.
  logic [2:0] pick;          // Lowest raised line, numbered from one.
  logic       fire;          // This edge sends an acknowledge.
  initial ack_valid = 1'b0;
  initial ack_line = 3'h0;
  // Answers the lowest raised line after lag cycles, one pulse at a time.
  // The line number is scrambled while idle, so no stale value can help.
  // Sampling on the rising edge avoids racing the bench, which moves go
  // and lag on the falling edge; answers go out by non-blocking update.
  always @(posedge clk)
  begin
    pick = 3'h0;
    for (int i = 5; i >= 0; i--)
      if (irq[i])
        pick = 3'(i + 1);
    fire = go && irq != 6'h00 && !ack_valid && wait_q >= lag;
    if (go && irq != 6'h00 && !ack_valid && wait_q < lag)
      wait_q <= wait_q + 4'h1;
    else
      wait_q <= 4'h0;
    ack_valid <= fire;
    ack_line <= fire ? pick : ~ack_line;
  end
endmodule

/* File: tb/piv_top_bench.sv */
// Self-checking bench for the interrupt expansion unit.
`timescale 1ns/10ps
module piv_top_bench;
  logic        sys_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        ce = 1'b1;
  logic [15:0] src_irq = 16'h0000;
  logic [15:0] src_en = 16'hffff;
  logic        low_mode = 1'b0;
  logic [5:0]  core_mask = 6'h3f;
  logic        wdog = 1'b0;
  logic        emu = 1'b0;
  logic        nmi = 1'b0;
  logic        go = 1'b0;
  logic [3:0]  lag = 4'h0;
  wire         ack_valid;
  wire  [2:0]  ack_line;
  wire  [5:0]  core_irq;
  wire  [15:0] vec_code;
  wire         vec_valid;
  wire  [47:0] pend;
  wire  [47:0] ack_flags;
  wire         entry_req;
  wire  [15:0] entry_vec;
  wire  [47:0] pend_absent;
  int          miscompares = 0;
  int          n_tests = 0;
  logic [15:0] evec [3] = '{16'h0000, 16'h0026, 16'h0024};
  // Rows: mode, source, flag position, core line, vector code.
  logic [31:0] rows [24] = '{32'h00011004, 32'h01021001, 32'h02031011,
    32'h03041005, 32'h04051006, 32'h05061007, 32'h06071040, 32'h07081041,
    32'h080c2027, 32'h090d2028, 32'h0a0e2029, 32'h0b0f202a, 32'h0c24202f,
    32'h0d252030, 32'h0e262031, 32'h0f272032, 32'h101c5004, 32'h111d6001,
    32'h121e6011, 32'h13175005, 32'h14185006, 32'h15195007, 32'h161a5040,
    32'h171b5041};
  always #10 sys_clk = ~sys_clk;
  // Main unit, every source present.
  piv_top dut (.SYS_CLK(sys_clk), .NRST(nrst), .CE(ce), .SRC_IRQ(src_irq),
    .SRC_EN(src_en), .LOW_PRI_MODE(low_mode), .CORE_MASK(core_mask),
    .WDOG_TIMEOUT(wdog), .EMU_TRAP(emu), .SW_NMI(nmi),
    .ACK_VALID(ack_valid), .ACK_LINE(ack_line), .CORE_IRQ(core_irq),
    .VEC_CODE(vec_code), .VEC_VALID(vec_valid), .PENDING_FLAGS(pend),
    .ACK_FLAGS(ack_flags), .ENTRY_REQ(entry_req), .ENTRY_VEC(entry_vec));
  // Variant without any peripheral; it must stay silent.
  piv_top #(.PRESENT(16'h0000)) dut_absent (.SYS_CLK(sys_clk),
    .NRST(nrst), .CE(ce), .SRC_IRQ(src_irq), .SRC_EN(src_en),
    .LOW_PRI_MODE(low_mode), .CORE_MASK(core_mask), .WDOG_TIMEOUT(wdog),
    .EMU_TRAP(emu), .SW_NMI(nmi), .ACK_VALID(ack_valid),
    .ACK_LINE(ack_line), .CORE_IRQ(), .VEC_CODE(), .VEC_VALID(),
    .PENDING_FLAGS(pend_absent), .ACK_FLAGS(), .ENTRY_REQ(),
    .ENTRY_VEC());
  // Core on the far side of the request lines.
  piv_core_model core (.clk(sys_clk), .irq(core_irq), .go(go), .lag(lag),
    .ack_valid(ack_valid), .ack_line(ack_line));
  // Counts one comparison and reports a mismatch.
  task automatic chk(input string what, input logic [47:0] e, g);
    n_tests++;
    if (g !== e)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // Lets the core take one request; the wait is bounded.
  task automatic take(input logic [15:0] code, input int pos);
    int k;
    cyc(1);
    go = 1'b1;
    for (k = 0; k < 12 && vec_valid !== 1'b1; k++)
      cyc(1);
    go = 1'b0;
    if (k == 12)
    begin
      miscompares++;
      end_sim();
    end
    chk("code", code, vec_code);
    chk("ack", 48'h1 << pos, ack_flags);
  endtask
  initial
  begin
    cyc(2);
    chk("entry", 48'h1, entry_req);
    chk("vector", 48'h0, entry_vec);
    nrst = 1'b1;
    cyc(3);
    $display("reset done");
    // Each source in high mode and the eight non-timer sources in low mode: flag, line, code, clear.
    foreach (rows[r])
    begin
      low_mode = rows[r][28];
      src_irq[rows[r][27:24]] = 1'b1;
      cyc(1);
      src_irq = 16'h0000;
      chk("flag", 48'h1 << rows[r][23:16], pend);
      chk("line", 48'h1 << (rows[r][15:12] - 4'h1), core_irq);
      take(rows[r][11:0], int'(rows[r][23:16]));
      chk("flag", 48'h0, pend);
    end
    chk("absent", 48'h0, pend_absent);
    $display("source table done");
    // Two pending on one line, slow core: lowest number first.
    low_mode = 1'b0;
    lag = 4'h2;
    src_irq = 16'h0300;
    cyc(1);
    src_irq = 16'h0000;
    take(16'h0027, 12);
    chk("line", 48'h2, core_irq);
    take(16'h0028, 13);
    chk("line", 48'h0, core_irq);
    lag = 4'h0;
    $display("arbitration done");
    // Event enable and core mask both gate.
    src_en = 16'hfffe;
    src_irq = 16'h0001;
    cyc(1);
    chk("flag", 48'h0, pend);
    src_en = 16'hffff;
    core_mask = 6'h3e;
    cyc(1);
    src_irq = 16'h0000;
    chk("flag", 48'h2, pend);
    chk("line", 48'h0, core_irq);
    core_mask = 6'h3f;
    cyc(1);
    chk("line", 48'h1, core_irq);
    take(16'h0004, 1);
    $display("masking done");
    // Entries fire with every line masked; two at once keep the higher.
    core_mask = 6'h00;
    for (int e = 0; e < 3; e++)
    begin
      {wdog, emu, nmi} = 3'h4 >> e;
      cyc(1);
      {wdog, emu, nmi} = 3'h0;
      chk("entry", 48'h1, entry_req);
      chk("vector", evec[e], entry_vec);
      cyc(1);
      chk("entry", 48'h0, entry_req);
    end
    {wdog, emu, nmi} = 3'h5;
    cyc(1);
    {wdog, emu, nmi} = 3'h0;
    chk("vector", 48'h0, entry_vec);
    $display("entries done");
    end_sim();
  end
endmodule
